// [rtl/ucc_pkg.sv]
// Shared constants, types and the register decoder for the UART channel control block.
// Assumes a 32-bit APB master with byte addresses and one aligned word per register.
package ucc_pkg;

	// Bus geometry.
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;

	// Register byte offsets.
	localparam logic [APB_AW-1:0] OFS_ERR_CLEAR = 8'h00;
	localparam logic [APB_AW-1:0] OFS_RX_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [APB_AW-1:0] OFS_PRIO_LOW = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_PRIO_HIGH = 8'h10;
	localparam logic [APB_AW-1:0] OFS_PORT_DATA = 8'h14;
	localparam logic [APB_AW-1:0] OFS_PORT_DIR = 8'h18;
	localparam logic [APB_AW-1:0] OFS_START_TRIG = 8'h1C;
	localparam logic [APB_AW-1:0] OFS_CHAN_STATUS = 8'h20;
	localparam logic [APB_AW-1:0] OFS_IRQ_REQ = 8'h24;

	// Error flag and clear trigger bit positions.
	localparam int BIT_OVERRUN = 0;
	localparam int BIT_PARITY = 1;
	localparam int BIT_FRAMING = 2;
	localparam int N_ERR = 3;

	// Interrupt source bit positions in mask, request and priority registers.
	localparam int SRC_TX_END = 0;
	localparam int SRC_RX_END = 1;
	localparam int SRC_RX_ERR = 2;
	localparam int N_SRC = 3;

	// Channel count of the start trigger and enable status.
	localparam int N_CHAN = 4;

	// Reset values.
	localparam logic [N_SRC-1:0] RST_IRQ_MASK = 3'h7;
	localparam logic [N_SRC-1:0] RST_PRIO = 3'h7;
	localparam logic [1:0] LVL_LOWEST = 2'h3;

	// Register selector.
	typedef enum {
		REG_ERR_CLEAR,
		REG_RX_STATUS,
		REG_IRQ_MASK,
		REG_PRIO_LOW,
		REG_PRIO_HIGH,
		REG_PORT_DATA,
		REG_PORT_DIR,
		REG_START_TRIG,
		REG_CHAN_STATUS,
		REG_IRQ_REQ,
		REG_NONE
	} ucc_reg_t;

	// One APB request as seen by the slave.
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [APB_AW-1:0] addr;
		logic [APB_DW-1:0] wdata;
	} ucc_apb_req_t;

	// Receive error events of one cycle.
	typedef struct packed {
		logic framing;
		logic parity;
		logic overrun;
	} ucc_rx_err_t;

	// Maps a byte address to its register.
	function automatic ucc_reg_t ucc_decode(input logic [APB_AW-1:0] addr);
		ucc_reg_t r;
		unique case (addr)
			OFS_ERR_CLEAR: r = REG_ERR_CLEAR;
			OFS_RX_STATUS: r = REG_RX_STATUS;
			OFS_IRQ_MASK: r = REG_IRQ_MASK;
			OFS_PRIO_LOW: r = REG_PRIO_LOW;
			OFS_PRIO_HIGH: r = REG_PRIO_HIGH;
			OFS_PORT_DATA: r = REG_PORT_DATA;
			OFS_PORT_DIR: r = REG_PORT_DIR;
			OFS_START_TRIG: r = REG_START_TRIG;
			OFS_CHAN_STATUS: r = REG_CHAN_STATUS;
			OFS_IRQ_REQ: r = REG_IRQ_REQ;
			default: r = REG_NONE;
		endcase
		return r;
	endfunction : ucc_decode

endpackage : ucc_pkg

// [rtl/ucc_sync.sv]
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps
module ucc_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = d_i;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign q_o = sync_reg;
endmodule : ucc_sync

// [rtl/ucc_flag.sv]
// Vector of sticky flags that hardware sets and another party clears.
// Assumes set and clear are one-cycle pulses on the same clock; set wins.
`timescale 1ns/1ps
module ucc_flag #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Set and clear pulses
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	// Flag state
	output logic [W-1:0] q_o
);
	logic [W-1:0] flag_reg;
	logic [W-1:0] flag_next;

	// An event in the clearing cycle is kept.
	always_comb begin
		flag_next = (flag_reg & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign q_o = flag_reg;
endmodule : ucc_flag

// [rtl/ucc_top.sv]
// Control and interrupt logic around one UART channel pair: channel 0 sends, channel 1 receives.
// Assumes an APB master on SYS_CLK_I, event pulses from the channels on the same clock, and pins outside.
//
// Overview of operation
// - Writing 1 to bit 2 of the error clear trigger clears the framing error flag, and 0 leaves it.
// - Writing 1 to bit 1 of the error clear trigger clears the parity error flag, and 0 leaves it.
// - Writing 1 to bit 0 of the error clear trigger clears the overrun error flag, and 0 leaves it.
// - A mask bit of 0 lets its source be serviced and 1 blocks it; bit 2 error, bit 1 rx end, bit 0 tx end.
// - A request flag reads 1 while its request is pending and 0 otherwise, with the same bit order.
// - Each source's priority is two bits, one from each priority register, where 00 is highest and 11 lowest.
// - In both priority registers rx error sits at bit 2, rx end at bit 1 and tx end at bit 0.
// - A direction bit of 0 turns the pin's output buffer on and 1 turns it off.
// - A pin in output mode drives low for a data bit of 0 and high for 1.
// - Writing 1 to a start trigger bit sets that channel's enable status and pulses its start output for one cycle.
// - The start trigger holds one bit per channel in bits 3 to 0, and each of channels 0 to 3 gets started by its bit.
// - Each receive error flag reads 1 once its error has happened and 0 when it has not.
`timescale 1ns/1ps
module ucc_top #(
	parameter int PORT_W = 8
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ucc_pkg::APB_AW-1:0] PADDR_I,
	input wire logic [ucc_pkg::APB_DW-1:0] PWDATA_I,
	output logic PREADY_O,
	output logic [ucc_pkg::APB_DW-1:0] PRDATA_O,
	output logic PSLVERR_O,
	// Channel events
	input wire logic RX_FRAMING_ERR_I,
	input wire logic RX_PARITY_ERR_I,
	input wire logic RX_OVERRUN_ERR_I,
	input wire logic RX_END_I,
	input wire logic TX_END_I,
	// Channel control
	output logic [ucc_pkg::N_CHAN-1:0] CHAN_ENABLE_O,
	output logic [ucc_pkg::N_CHAN-1:0] CHAN_START_O,
	// Interrupt request
	output logic IRQ_VALID_O,
	output logic [1:0] IRQ_SOURCE_O,
	output logic [1:0] IRQ_LEVEL_O,
	// Port pins
	input wire logic [PORT_W-1:0] PORT_PIN_I,
	output logic [PORT_W-1:0] PORT_DATA_O,
	output logic [PORT_W-1:0] PORT_OE_O
);
	if (PORT_W < 3 || PORT_W > ucc_pkg::APB_DW) begin : g_bad_port_w
		$error("PORT_W must lie between 3 and 32.");
	end

	// Bus request and decode.
	ucc_pkg::ucc_apb_req_t req;
	ucc_pkg::ucc_reg_t idx;
	ucc_pkg::ucc_rx_err_t err_ev;
	logic setup;
	logic wr;
	logic clr_wr;
	logic start_wr;
	logic req_wr;

	assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};
	assign err_ev = '{framing: RX_FRAMING_ERR_I, parity: RX_PARITY_ERR_I, overrun: RX_OVERRUN_ERR_I};
	assign idx = ucc_pkg::ucc_decode(req.addr);
	assign setup = req.sel && !req.enable;

	// Writes take effect at the edge that completes the access phase.
	logic pready_reg;
	assign wr = req.sel && req.enable && pready_reg && req.write;
	assign clr_wr = wr && (idx == ucc_pkg::REG_ERR_CLEAR);
	assign start_wr = wr && (idx == ucc_pkg::REG_START_TRIG);
	assign req_wr = wr && (idx == ucc_pkg::REG_IRQ_REQ);

	// Pin inputs cross into the clock domain first.
	logic [PORT_W-1:0] pin_sync;

	ucc_sync #(
		.W(PORT_W)
	) u_pin_sync (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.d_i(PORT_PIN_I),
		.q_o(pin_sync)
	);

	// Receive error flags.
	logic [ucc_pkg::N_ERR-1:0] err_set;
	logic [ucc_pkg::N_ERR-1:0] err_clr;
	logic [ucc_pkg::N_ERR-1:0] err_q;

	always_comb begin
		err_set = '0;
		err_set[ucc_pkg::BIT_FRAMING] = err_ev.framing;
		err_set[ucc_pkg::BIT_PARITY] = err_ev.parity;
		err_set[ucc_pkg::BIT_OVERRUN] = err_ev.overrun;
		err_clr = '0;
		err_clr[ucc_pkg::BIT_FRAMING] = clr_wr && req.wdata[ucc_pkg::BIT_FRAMING];
		err_clr[ucc_pkg::BIT_PARITY] = clr_wr && req.wdata[ucc_pkg::BIT_PARITY];
		err_clr[ucc_pkg::BIT_OVERRUN] = clr_wr && req.wdata[ucc_pkg::BIT_OVERRUN];
	end

	// The clear trigger itself is never stored; it only pulses the flags.
	ucc_flag #(
		.W(ucc_pkg::N_ERR)
	) u_err_flag (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.set_i(err_set),
		.clr_i(err_clr),
		.q_o(err_q)
	);

	// Interrupt request flags.
	logic [ucc_pkg::N_SRC-1:0] irq_set;
	logic [ucc_pkg::N_SRC-1:0] irq_clr;
	logic [ucc_pkg::N_SRC-1:0] irq_q;

	always_comb begin
		irq_set = '0;
		irq_set[ucc_pkg::SRC_RX_ERR] = |err_set;
		irq_set[ucc_pkg::SRC_RX_END] = RX_END_I;
		irq_set[ucc_pkg::SRC_TX_END] = TX_END_I;
		irq_clr = '0;
		if (req_wr) begin
			irq_set = irq_set | req.wdata[ucc_pkg::N_SRC-1:0];
			irq_clr = ~req.wdata[ucc_pkg::N_SRC-1:0];
		end
	end

	ucc_flag #(
		.W(ucc_pkg::N_SRC)
	) u_irq_flag (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.q_o(irq_q)
	);

	// Picks the pending source of the best level; on a tie the higher bit wins.
	function automatic logic [4:0] ucc_pick(input logic [ucc_pkg::N_SRC-1:0] pend,
			input logic [ucc_pkg::N_SRC-1:0] lo, input logic [ucc_pkg::N_SRC-1:0] hi);
		logic found;
		logic [1:0] src;
		logic [1:0] best;
		logic [1:0] lvl;
		found = 1'b0;
		src = '0;
		best = ucc_pkg::LVL_LOWEST;
		for (int i = ucc_pkg::N_SRC - 1; i >= 0; i--) begin
			lvl = {hi[i], lo[i]};
			if (pend[i] && (!found || lvl < best)) begin
				found = 1'b1;
				src = 2'(i);
				best = lvl;
			end
		end
		return {found, src, best};
	endfunction : ucc_pick

	// Software registers and bus answer.
	logic [ucc_pkg::N_SRC-1:0] mask_reg;
	logic [ucc_pkg::N_SRC-1:0] mask_next;
	logic [ucc_pkg::N_SRC-1:0] prio_lo_reg;
	logic [ucc_pkg::N_SRC-1:0] prio_lo_next;
	logic [ucc_pkg::N_SRC-1:0] prio_hi_reg;
	logic [ucc_pkg::N_SRC-1:0] prio_hi_next;
	logic [PORT_W-1:0] pdata_reg;
	logic [PORT_W-1:0] pdata_next;
	logic [PORT_W-1:0] pdir_reg;
	logic [PORT_W-1:0] pdir_next;
	logic [PORT_W-1:0] poe_reg;
	logic [PORT_W-1:0] poe_next;
	logic [ucc_pkg::N_CHAN-1:0] chan_en_reg;
	logic [ucc_pkg::N_CHAN-1:0] chan_en_next;
	logic [ucc_pkg::N_CHAN-1:0] start_reg;
	logic [ucc_pkg::N_CHAN-1:0] start_next;
	logic pready_next;
	logic [ucc_pkg::APB_DW-1:0] prdata_reg;
	logic [ucc_pkg::APB_DW-1:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic irq_valid_reg;
	logic irq_valid_next;
	logic [1:0] irq_src_reg;
	logic [1:0] irq_src_next;
	logic [1:0] irq_lvl_reg;
	logic [1:0] irq_lvl_next;
	logic [ucc_pkg::APB_DW-1:0] rd_val;
	logic [PORT_W-1:0] port_view;
	logic [4:0] pick;

	always_comb begin
		mask_next = mask_reg;
		prio_lo_next = prio_lo_reg;
		prio_hi_next = prio_hi_reg;
		pdata_next = pdata_reg;
		pdir_next = pdir_reg;
		if (wr) begin
			unique case (idx)
				ucc_pkg::REG_IRQ_MASK: mask_next = req.wdata[ucc_pkg::N_SRC-1:0];
				ucc_pkg::REG_PRIO_LOW: prio_lo_next = req.wdata[ucc_pkg::N_SRC-1:0];
				ucc_pkg::REG_PRIO_HIGH: prio_hi_next = req.wdata[ucc_pkg::N_SRC-1:0];
				ucc_pkg::REG_PORT_DATA: pdata_next = req.wdata[PORT_W-1:0];
				ucc_pkg::REG_PORT_DIR: pdir_next = req.wdata[PORT_W-1:0];
				default: begin
				end
			endcase
		end
		poe_next = ~pdir_next;
		start_next = start_wr ? req.wdata[ucc_pkg::N_CHAN-1:0] : '0;
		chan_en_next = chan_en_reg | start_next;
		pick = ucc_pick(irq_q & ~mask_reg, prio_lo_reg, prio_hi_reg);
		irq_valid_next = pick[4];
		irq_src_next = pick[3:2];
		irq_lvl_next = pick[1:0];
	end

	// Read value is captured in the setup cycle; reads have no side effects.
	always_comb begin
		rd_val = '0;
		for (int i = 0; i < PORT_W; i++) begin
			port_view[i] = pdir_reg[i] ? pin_sync[i] : pdata_reg[i];
		end
		unique case (idx)
			ucc_pkg::REG_ERR_CLEAR: rd_val = '0;
			ucc_pkg::REG_RX_STATUS: rd_val[ucc_pkg::N_ERR-1:0] = err_q;
			ucc_pkg::REG_IRQ_MASK: rd_val[ucc_pkg::N_SRC-1:0] = mask_reg;
			ucc_pkg::REG_PRIO_LOW: rd_val[ucc_pkg::N_SRC-1:0] = prio_lo_reg;
			ucc_pkg::REG_PRIO_HIGH: rd_val[ucc_pkg::N_SRC-1:0] = prio_hi_reg;
			ucc_pkg::REG_PORT_DATA: rd_val[PORT_W-1:0] = port_view;
			ucc_pkg::REG_PORT_DIR: rd_val[PORT_W-1:0] = pdir_reg;
			ucc_pkg::REG_START_TRIG: rd_val = '0;
			ucc_pkg::REG_CHAN_STATUS: rd_val[ucc_pkg::N_CHAN-1:0] = chan_en_reg;
			ucc_pkg::REG_IRQ_REQ: rd_val[ucc_pkg::N_SRC-1:0] = irq_q;
			ucc_pkg::REG_NONE: rd_val = '0;
		endcase
		pready_next = setup;
		prdata_next = setup ? rd_val : '0;
		pslverr_next = setup && (idx == ucc_pkg::REG_NONE);
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mask_reg <= ucc_pkg::RST_IRQ_MASK;
			prio_lo_reg <= ucc_pkg::RST_PRIO;
			prio_hi_reg <= ucc_pkg::RST_PRIO;
			pdata_reg <= '0;
			pdir_reg <= '1;
			poe_reg <= '0;
			chan_en_reg <= '0;
			start_reg <= '0;
			pready_reg <= 1'b0;
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
			irq_valid_reg <= 1'b0;
			irq_src_reg <= '0;
			irq_lvl_reg <= '0;
		end else begin
			mask_reg <= mask_next;
			prio_lo_reg <= prio_lo_next;
			prio_hi_reg <= prio_hi_next;
			pdata_reg <= pdata_next;
			pdir_reg <= pdir_next;
			poe_reg <= poe_next;
			chan_en_reg <= chan_en_next;
			start_reg <= start_next;
			pready_reg <= pready_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
			irq_valid_reg <= irq_valid_next;
			irq_src_reg <= irq_src_next;
			irq_lvl_reg <= irq_lvl_next;
		end
	end

	assign PREADY_O = pready_reg;
	assign PRDATA_O = prdata_reg;
	assign PSLVERR_O = pslverr_reg;
	assign CHAN_ENABLE_O = chan_en_reg;
	assign CHAN_START_O = start_reg;
	assign IRQ_VALID_O = irq_valid_reg;
	assign IRQ_SOURCE_O = irq_src_reg;
	assign IRQ_LEVEL_O = irq_lvl_reg;
	assign PORT_DATA_O = pdata_reg;
	assign PORT_OE_O = poe_reg;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);

	a_framing_clear: assert property (
		clr_wr && req.wdata[ucc_pkg::BIT_FRAMING] && !err_ev.framing |=> !err_q[ucc_pkg::BIT_FRAMING])
		else $error("Framing flag survived its clear.");

	a_parity_clear: assert property (
		clr_wr && req.wdata[ucc_pkg::BIT_PARITY] && !err_ev.parity |=> !err_q[ucc_pkg::BIT_PARITY])
		else $error("Parity flag survived its clear.");

	a_overrun_clear: assert property (
		clr_wr && req.wdata[ucc_pkg::BIT_OVERRUN] && !err_ev.overrun |=> !err_q[ucc_pkg::BIT_OVERRUN])
		else $error("Overrun flag survived its clear.");

	a_flag_sticky: assert property (
		$fell(err_q[ucc_pkg::BIT_FRAMING]) |-> $past(clr_wr) && $past(req.wdata[ucc_pkg::BIT_FRAMING]))
		else $error("Framing flag fell without a clear.");

	a_error_sets: assert property (
		err_ev.overrun |=> err_q[ucc_pkg::BIT_OVERRUN] ##1 irq_valid_reg || mask_reg[ucc_pkg::SRC_RX_ERR])
		else $error("Overrun event lost.");

	a_mask_gate: assert property (
		IRQ_VALID_O |-> !$past(mask_reg[irq_src_next]) && $past(irq_q[irq_src_next]))
		else $error("Masked or idle source was presented.");

	a_rx_end_req: assert property (
		RX_END_I && !(req_wr && !req.wdata[ucc_pkg::SRC_RX_END]) |=> irq_q[ucc_pkg::SRC_RX_END])
		else $error("Reception end request not raised.");

	a_prio_level: assert property (
		IRQ_VALID_O |-> IRQ_LEVEL_O == {$past(prio_hi_reg[irq_src_next]), $past(prio_lo_reg[irq_src_next])})
		else $error("Presented level does not match priority bits.");

	a_port_dir: assert property (
		wr && idx == ucc_pkg::REG_PORT_DIR |=> PORT_OE_O == ~$past(req.wdata[PORT_W-1:0]))
		else $error("Output enable does not follow direction.");

	a_start_chan: assert property (
		start_wr && req.wdata[0] |=> CHAN_START_O[0] && CHAN_ENABLE_O[0] ##1 !CHAN_START_O[0] || $past(start_wr))
		else $error("Channel start did not enable the channel.");
endmodule : ucc_top

// [sim/ucc_remote.sv]
// Model of the far side: channel event pulses and the levels of the pins it owns.
// Assumes the bench calls its tasks from one process, on the block's clock.
`timescale 1ns/1ps
module ucc_remote (
	// Clock
	input wire logic clk_i,
	// Channel events
	output logic tx_end_o,
	output logic rx_end_o,
	output logic overrun_o,
	output logic parity_o,
	output logic framing_o,
	// Pin levels
	output logic [7:0] pins_o
);
	logic [4:0] ev_reg = 5'h00;

	initial pins_o = 8'hFF;
	assign {framing_o, parity_o, overrun_o, rx_end_o, tx_end_o} = ev_reg;

	// Each event lasts exactly one cycle, launched just after a rising edge.
	task automatic pulse(input logic [4:0] ev);
		@(posedge clk_i);
		ev_reg <= ev;
		@(posedge clk_i);
		ev_reg <= 5'h00;
	endtask : pulse

	task automatic drive(input logic [7:0] v);
		@(posedge clk_i);
		pins_o <= v;
	endtask : drive
endmodule : ucc_remote

// [sim/ucc_top_tb.sv]
// Self-checking bench for the UART channel control block.
// Assumes the remote model beside it and an APB master built from tasks.
`timescale 1ns/1ps
module ucc_top_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pready, pslverr, irq_valid, fe, pe, ov, re, te;
	logic [31:0] prdata;
	logic [1:0] irq_src, irq_lvl;
	logic [3:0] chan_en, chan_start;
	logic [7:0] pin, pdata, poe, rpins;
	logic [33:0] exp_q[$];
	int n_mismatch = 0;
	int checks = 0;
	int seed = 85;
	int cycles = 0;

	always #10 clk = ~clk;
	assign pin = (poe & pdata) | (~poe & rpins);

	ucc_remote rmt (.clk_i(clk), .tx_end_o(te), .rx_end_o(re), .overrun_o(ov), .parity_o(pe),
		.framing_o(fe), .pins_o(rpins));

	ucc_top #(.PORT_W(8)) dut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PRDATA_O(prdata),
		.PSLVERR_O(pslverr), .RX_FRAMING_ERR_I(fe), .RX_PARITY_ERR_I(pe), .RX_OVERRUN_ERR_I(ov),
		.RX_END_I(re), .TX_END_I(te), .CHAN_ENABLE_O(chan_en), .CHAN_START_O(chan_start),
		.IRQ_VALID_O(irq_valid), .IRQ_SOURCE_O(irq_src), .IRQ_LEVEL_O(irq_lvl),
		.PORT_PIN_I(pin), .PORT_DATA_O(pdata), .PORT_OE_O(poe));

	task automatic final_report();
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// The expected answer is queued; the monitor below compares it when the slave answers.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err,
		input logic [31:0] exp);
		exp_q.push_back({w, err, exp});
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0, 32'h0000_0000);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 1'b0, e);
	endtask : rd

	always @(posedge clk) begin
		logic [33:0] e;
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			cmp("slave error", {31'h0, e[32]}, {31'h0, pslverr});
			if (!e[33])
				cmp("read data", e[31:0], prdata);
		end
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		logic [2:0] lo, hi, st;
		logic [7:0] dir, dat, dn;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(ucc_pkg::OFS_IRQ_MASK, 32'h7);
		rd(ucc_pkg::OFS_PRIO_LOW, 32'h7);
		rd(ucc_pkg::OFS_PRIO_HIGH, 32'h7);
		rd(ucc_pkg::OFS_PORT_DIR, 32'hFF);
		rd(ucc_pkg::OFS_RX_STATUS, 32'h0);
		rd(ucc_pkg::OFS_IRQ_REQ, 32'h0);
		rd(ucc_pkg::OFS_CHAN_STATUS, 32'h0);
		apb(1'b0, 8'h28, 32'h0, 1'b1, 32'h0);
		apb(1'b1, 8'h2C, 32'h7, 1'b1, 32'h0);
		// All three errors at once, then a zero write, then one clear at a time.
		rmt.pulse(5'h1C);
		rd(ucc_pkg::OFS_RX_STATUS, 32'h7);
		rd(ucc_pkg::OFS_IRQ_REQ, 32'h4);
		wr(ucc_pkg::OFS_ERR_CLEAR, 32'h0);
		rd(ucc_pkg::OFS_ERR_CLEAR, 32'h0);
		st = 3'h7;
		for (int b = 0; b < 3; b++) begin
			rd(ucc_pkg::OFS_RX_STATUS, {29'h0, st});
			wr(ucc_pkg::OFS_ERR_CLEAR, 32'h1 << b);
			st[b] = 1'b0;
		end
		rd(ucc_pkg::OFS_RX_STATUS, 32'h0);
		lo = 3'($random(seed));
		hi = 3'($random(seed));
		wr(ucc_pkg::OFS_PRIO_LOW, {29'h0, lo});
		wr(ucc_pkg::OFS_PRIO_HIGH, {29'h0, hi});
		rd(ucc_pkg::OFS_PRIO_LOW, {29'h0, lo});
		rd(ucc_pkg::OFS_PRIO_HIGH, {29'h0, hi});
		for (int s = 0; s < 3; s++) begin
			wr(ucc_pkg::OFS_IRQ_REQ, 32'h0);
			wr(ucc_pkg::OFS_IRQ_MASK, 32'h7 ^ (32'h1 << s));
			rmt.pulse(s == 2 ? 5'h10 : 5'h01 << s);
			repeat (3) @(posedge clk);
			@(negedge clk);
			cmp("irq valid", 32'h1, {31'h0, irq_valid});
			cmp("irq source", s, {30'h0, irq_src});
			cmp("irq level", {hi[s], lo[s]}, {30'h0, irq_lvl});
			rd(ucc_pkg::OFS_IRQ_REQ, 32'h1 << s);
			wr(ucc_pkg::OFS_IRQ_MASK, 32'h7);
			repeat (3) @(negedge clk);
			cmp("irq valid", 32'h0, {31'h0, irq_valid});
		end
		for (int i = 0; i < 4; i++) begin
			dir = (8'($random(seed)) & 8'hF9) | 8'h02;
			dat = 8'($random(seed)) | 8'h04;
			dn = ~dir;
			rmt.drive(8'($random(seed)));
			wr(ucc_pkg::OFS_PORT_DATA, {24'h0, dat});
			wr(ucc_pkg::OFS_PORT_DIR, {24'h0, dir});
			repeat (4) @(negedge clk);
			cmp("pin enable", {24'h0, dn}, {24'h0, poe});
			cmp("pin data", {24'h0, dat}, {24'h0, pdata});
			cmp("tx pin level", 32'h1, {31'h0, pin[2]});
			rd(ucc_pkg::OFS_PORT_DATA, {24'h0, (dat & dn) | (rpins & dir)});
		end
		repeat (4) @(posedge clk);
		wr(ucc_pkg::OFS_START_TRIG, 32'h0);
		@(negedge clk);
		cmp("start pulse", 32'h0, {28'h0, chan_start});
		wr(ucc_pkg::OFS_START_TRIG, 32'h3);
		@(negedge clk);
		cmp("start pulse", 32'h3, {28'h0, chan_start});
		@(negedge clk);
		cmp("start pulse", 32'h0, {28'h0, chan_start});
		cmp("enable status", 32'h3, {28'h0, chan_en});
		wr(ucc_pkg::OFS_START_TRIG, 32'h8);
		rd(ucc_pkg::OFS_CHAN_STATUS, 32'hB);
		final_report();
	end
endmodule : ucc_top_tb
